// *** include/azt_pkg.sv ***
package azt_pkg;

    localparam int ZONES = 4;
    localparam int CHANS = 4;
    localparam int THR_W = 13;

    // thresholds in hundredths of nominal current (step 0.01)
    localparam logic [12:0] PH_THR_RST  = 13'h0078;
    localparam logic [12:0] RES_THR_RST = 13'h0078;

    // program cycle is 5 ms at 25 MHz
    localparam int CLK_HZ       = 25000000;
    localparam int CYCLE_US     = 5000;
    localparam int CYCLE_CLKS   = CYCLE_US * (CLK_HZ / 1000000);
    localparam int SAMPLES_RST  = 1;

    // register offsets
    localparam logic [3:0] A_ZONE_EN   = 4'h0;
    localparam logic [3:0] A_PH_EN     = 4'h1;
    localparam logic [3:0] A_RES_EN    = 4'h2;
    localparam logic [3:0] A_LIGHT_EN  = 4'h3;
    localparam logic [3:0] A_PRES_EN   = 4'h4;
    localparam logic [3:0] A_DI_MODE   = 4'h5;
    localparam logic [3:0] A_PH_THR    = 4'h6;
    localparam logic [3:0] A_RES_THR   = 4'h7;
    localparam logic [3:0] A_RES_SEL   = 4'h8;
    localparam logic [3:0] A_SAMPLES   = 4'h9;
    localparam logic [3:0] A_SENS_CFG  = 4'hA;
    localparam logic [3:0] A_CONDITION = 4'hB;
    localparam logic [3:0] A_SENS_STAT = 4'hC;

    typedef enum logic [1:0] {
        DI_OFF   = 2'b00,
        DI_LIGHT = 2'b01,
        DI_CURR  = 2'b10
    } azt_di_mode_t;

    typedef enum logic [1:0] {
        RS_NONE = 2'b00,
        RS_ONE  = 2'b01,
        RS_TWO  = 2'b10
    } azt_res_sel_t;

endpackage

// *** rtl/azt_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module azt_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // change accepted once stages two and three agree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            q_out <= '0;
        end else begin
            s1_q <= d_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/azt_cur_cond.sv ***
`timescale 1ns/1ps
`default_nettype none
module azt_cur_cond (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        sample_in,
    input  wire logic        over_in,
    input  wire logic [7:0]  need_in,
    output logic             cond_out
);
    logic [7:0] cnt_q;

    // consecutive over-limit samples; any sample at or below the limit clears
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cnt_q    <= 8'h00;
            cond_out <= 1'b0;
        end else if (sample_in) begin
            if (over_in) begin
                if (cnt_q != 8'hFF) begin
                    cnt_q <= cnt_q + 8'h01;
                end
                // nine bits so a saturated count does not wrap and drop the condition
                cond_out <= (({1'b0, cnt_q} + 9'h001) >= {1'b0, need_in});
            end else begin
                cnt_q    <= 8'h00;
                cond_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/azt_zone_trip.sv ***
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - four zones, each enabled separately; disabled zone never trips or blocks
// - phase threshold in hundredths of nominal, reset value 1.20
// - residual threshold in hundredths of nominal, reset value 1.20
// - residual source select: none, channel one or two; default none
// - zone pick-up depends on which current and sensor inputs are enabled
// - phase enable: light trips only while phase overcurrent holds
// - residual enable: light trips only while residual overcurrent holds
// - per-zone light enable for each of four channels
// - per-zone pressure enable for each of four channels
// - digital input modes off, light, current; light mode trips alone
// - current mode trips only with digital input and a channel detection
// - settings change at any time without halting the trip logic
// - live trip and blocked flags per zone
// - live sensor status: current blocked/start, light, pressure, input, faults
// - blocking input sampled at the start of each program cycle
// - pick-up with blocking inactive asserts the zone trip
// - pick-up with blocking active gives blocked, no trip for that event
// - current condition after required number of over-limit 5 ms samples
// - channel configuration fault when sensed count differs from configured
// cycle length overridable; default is the 5 ms program cycle
module azt_zone_trip #(
    parameter int CYC_CLKS = azt_pkg::CYCLE_CLKS
) (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic [3:0]  light_in,
    input  wire logic [3:0]  pres_in,
    input  wire logic        di_in,
    input  wire logic        block_in,
    input  wire logic        io_fault_in,
    input  wire logic [7:0]  sens_count_in,
    input  wire logic [12:0] ph_cur_in,
    input  wire logic [12:0] res1_cur_in,
    input  wire logic [12:0] res2_cur_in,
    input  wire logic        sample_in,
    output logic      [3:0]  trip_out,
    output logic      [3:0]  blocked_out,
    output logic             ph_start_out,
    output logic             res_start_out,
    output logic             ph_blocked_out,
    output logic             res_blocked_out,
    output logic      [3:0]  sens_fault_out
);
    logic [3:0]  zone_en_q;
    logic [3:0]  ph_en_q;
    logic [3:0]  res_en_q;
    logic [15:0] light_en_q;
    logic [15:0] pres_en_q;
    logic [7:0]  di_mode_q;
    logic [12:0] ph_thr_q;
    logic [12:0] res_thr_q;
    logic [1:0]  res_sel_q;
    logic [7:0]  samples_q;
    logic [7:0]  sens_cfg_q;
    logic [23:0] cyc_cnt_q;
    logic        cyc_tick_q;
    logic        block_q;
    logic [3:0]  pick_q;
    logic [3:0]  pick_d;

    logic [3:0]  light_s;
    logic [3:0]  pres_s;
    logic        di_s;
    logic        block_s;
    logic        iof_s;
    logic [7:0]  cnt_s;
    logic        ph_cond;
    logic        res_cond;
    logic [12:0] res_cur;
    logic        samp_s;

    azt_sync #(.W(20)) u_sync (
        .clock_in (clock_in),
        .rst_in   (rst_in),
        .d_in     ({light_in, pres_in, di_in, block_in, io_fault_in, sens_count_in,
                    sample_in}),
        .q_out    ({light_s, pres_s, di_s, block_s, iof_s, cnt_s, samp_s})
    );

    // register writes; settings take effect next cycle, logic never halts
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            zone_en_q  <= 4'h0;
            ph_en_q    <= 4'h0;
            res_en_q   <= 4'h0;
            light_en_q <= 16'h0000;
            pres_en_q  <= 16'h0000;
            di_mode_q  <= 8'h00;
            ph_thr_q   <= azt_pkg::PH_THR_RST;
            res_thr_q  <= azt_pkg::RES_THR_RST;
            res_sel_q  <= azt_pkg::RS_NONE;
            samples_q  <= 8'(azt_pkg::SAMPLES_RST);
            sens_cfg_q <= 8'h00;
        end else if (wr_in) begin
            unique case (addr_in)
                azt_pkg::A_ZONE_EN:  zone_en_q  <= wdata_in[3:0];
                azt_pkg::A_PH_EN:    ph_en_q    <= wdata_in[3:0];
                azt_pkg::A_RES_EN:   res_en_q   <= wdata_in[3:0];
                azt_pkg::A_LIGHT_EN: light_en_q <= wdata_in[15:0];
                azt_pkg::A_PRES_EN:  pres_en_q  <= wdata_in[15:0];
                azt_pkg::A_DI_MODE:  di_mode_q  <= wdata_in[7:0];
                azt_pkg::A_PH_THR:   ph_thr_q   <= wdata_in[12:0];
                azt_pkg::A_RES_THR:  res_thr_q  <= wdata_in[12:0];
                azt_pkg::A_RES_SEL:  res_sel_q  <= wdata_in[1:0];
                azt_pkg::A_SAMPLES:  samples_q  <= wdata_in[7:0];
                azt_pkg::A_SENS_CFG: sens_cfg_q <= wdata_in[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (res_sel_q)
            azt_pkg::RS_ONE: res_cur = res1_cur_in;
            azt_pkg::RS_TWO: res_cur = res2_cur_in;
            default:         res_cur = 13'h0000;
        endcase
    end

    azt_cur_cond u_ph (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .sample_in (samp_s),
        .over_in   (ph_cur_in > ph_thr_q),
        .need_in   (samples_q),
        .cond_out  (ph_cond)
    );

    azt_cur_cond u_res (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .sample_in (samp_s),
        .over_in   ((res_sel_q != azt_pkg::RS_NONE) && (res_cur > res_thr_q)),
        .need_in   (samples_q),
        .cond_out  (res_cond)
    );

    // program cycle divider
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cyc_cnt_q  <= 24'h000000;
            cyc_tick_q <= 1'b0;
        end else if (cyc_cnt_q == 24'(CYC_CLKS - 1)) begin
            cyc_cnt_q  <= 24'h000000;
            cyc_tick_q <= 1'b1;
        end else begin
            cyc_cnt_q  <= cyc_cnt_q + 24'h000001;
            cyc_tick_q <= 1'b0;
        end
    end

    // block latched at cycle start for the current start/blocked flags; zone outputs use block_s
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            block_q <= 1'b0;
        end else if (cyc_tick_q) begin
            block_q <= block_s;
        end
    end

    genvar z;
    generate
        for (z = 0; z < azt_pkg::ZONES; z++) begin : g_zone
            logic [3:0] lit;
            logic [3:0] prs;
            logic       any_det;
            logic [1:0] mode;
            logic       det;
            assign lit     = light_s & light_en_q[4*z +: 4];
            assign prs     = pres_s  & pres_en_q[4*z +: 4];
            assign any_det = |(light_s | pres_s);
            assign mode    = di_mode_q[2*z +: 2];
            assign det = (|lit) || (|prs)
                      || (mode == azt_pkg::DI_LIGHT && di_s)
                      || (mode == azt_pkg::DI_CURR && di_s && any_det);
            // pick-up: detections gated by each enabled current condition
            assign pick_d[z] = zone_en_q[z] && det
                            && (!ph_en_q[z] || ph_cond)
                            && (!res_en_q[z] || res_cond);
        end
    endgenerate

    // outputs evaluated once per program cycle, on the same edge that loads block_q, from block_s
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pick_q      <= 4'h0;
            trip_out    <= 4'h0;
            blocked_out <= 4'h0;
        end else if (cyc_tick_q) begin
            pick_q <= pick_d;
            for (int i = 0; i < azt_pkg::ZONES; i++) begin
                if (!pick_d[i]) begin
                    trip_out[i]    <= 1'b0;
                    blocked_out[i] <= 1'b0;
                end else if (!pick_q[i]) begin
                    // decision fixed at pick-up; no re-evaluation for this event
                    trip_out[i]    <= !block_s;
                    blocked_out[i] <= block_s;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ph_start_out    <= 1'b0;
            res_start_out   <= 1'b0;
            ph_blocked_out  <= 1'b0;
            res_blocked_out <= 1'b0;
            sens_fault_out  <= 4'h0;
        end else begin
            ph_start_out    <= ph_cond && !block_q;
            res_start_out   <= res_cond && !block_q;
            ph_blocked_out  <= ph_cond && block_q;
            res_blocked_out <= res_cond && block_q;
            for (int c = 0; c < azt_pkg::CHANS; c++) begin
                sens_fault_out[c] <= cnt_s[2*c +: 2] != sens_cfg_q[2*c +: 2];
            end
        end
    end

    // read port, data valid in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            unique case (addr_in)
                azt_pkg::A_ZONE_EN:   rdata_out <= {28'h0, zone_en_q};
                azt_pkg::A_PH_EN:     rdata_out <= {28'h0, ph_en_q};
                azt_pkg::A_RES_EN:    rdata_out <= {28'h0, res_en_q};
                azt_pkg::A_LIGHT_EN:  rdata_out <= {16'h0, light_en_q};
                azt_pkg::A_PRES_EN:   rdata_out <= {16'h0, pres_en_q};
                azt_pkg::A_DI_MODE:   rdata_out <= {24'h0, di_mode_q};
                azt_pkg::A_PH_THR:    rdata_out <= {19'h0, ph_thr_q};
                azt_pkg::A_RES_THR:   rdata_out <= {19'h0, res_thr_q};
                azt_pkg::A_RES_SEL:   rdata_out <= {30'h0, res_sel_q};
                azt_pkg::A_SAMPLES:   rdata_out <= {24'h0, samples_q};
                azt_pkg::A_SENS_CFG:  rdata_out <= {24'h0, sens_cfg_q};
                azt_pkg::A_CONDITION: rdata_out <= {24'h0, blocked_out, trip_out};
                azt_pkg::A_SENS_STAT: rdata_out <= {10'h0, iof_s, sens_fault_out, di_s,
                                                    pres_s, light_s, 4'h0, res_start_out,
                                                    res_blocked_out, ph_start_out,
                                                    ph_blocked_out};
                default:              rdata_out <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** tb/azt_field_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module azt_field_model (
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic [12:0] ph_cmd_in,
    input  wire logic [12:0] res_cmd_in,
    output logic      [12:0] ph_out,
    output logic      [12:0] res_out,
    output logic             sample_out
);
    logic [9:0] cnt_q;
    // two-clock sample strobe: a one-clock pulse never passes the input filter
    always_ff @(posedge clock_in) begin
        cnt_q <= rst_in ? 10'h000 : cnt_q + 10'h001;
        sample_out <= !rst_in && cnt_q >= 10'h3FE;
    end
    // currents move only at frame start, never under a strobe
    always_ff @(posedge clock_in) begin
        if (cnt_q == 10'h000) begin
            ph_out <= ph_cmd_in;
            res_out <= res_cmd_in;
        end
    end
endmodule
`default_nettype wire

// *** tb/azt_zone_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module azt_zone_monitor (
    input wire logic        clock_in,
    input wire logic        rst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [3:0]  trip_out,
    input wire logic [3:0]  blocked_out,
    input wire logic        ph_start_out,
    input wire logic        ph_blocked_out,
    input wire logic        res_start_out,
    input wire logic        res_blocked_out,
    input wire logic [3:0]  sens_fault_out
);
    logic [3:0] ever_en_q;
    // zones never enabled since reset must stay silent
    always_ff @(posedge clock_in) begin
        if (rst_in)
            ever_en_q <= 4'h0;
        else if (wr_in && addr_in == azt_pkg::A_ZONE_EN)
            ever_en_q <= ever_en_q | wdata_in[3:0];
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    a_reset_clear: assert property ($fell(rst_in) |->
        trip_out == 4'h0 && blocked_out == 4'h0 && sens_fault_out == 4'h0)
        else $error("outputs not clear after reset");
    a_trip_blk_excl: assert property ((trip_out & blocked_out) == 4'h0)
        else $error("zone shows trip and blocked together");
    a_dis_quiet: assert property (((trip_out | blocked_out) & ~ever_en_q) == 4'h0)
        else $error("disabled zone raised an indication");
    a_cond_hold: assert property ($changed({trip_out, blocked_out}) |=>
        $stable({trip_out, blocked_out}) [*8])
        else $error("zone indication moved between program cycles");
    a_unmapped_zero: assert property (rd_in && addr_in > azt_pkg::A_SENS_STAT |=>
        rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_cond_read: assert property (rd_in && addr_in == azt_pkg::A_CONDITION |=>
        rdata_out[7:0] == {$past(blocked_out), $past(trip_out)})
        else $error("condition read differs from outputs");
    a_stat_read: assert property (rd_in && addr_in == azt_pkg::A_SENS_STAT |=>
        rdata_out[20:17] == $past(sens_fault_out) && rdata_out[0] == $past(ph_blocked_out))
        else $error("status read differs from outputs");
    a_start_excl: assert property (!(ph_start_out && ph_blocked_out) &&
        !(res_start_out && res_blocked_out))
        else $error("current start and blocked together");
endmodule
bind azt_zone_trip azt_zone_monitor u_mon (.clock_in, .rst_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .trip_out, .blocked_out, .ph_start_out, .ph_blocked_out,
    .res_start_out, .res_blocked_out, .sens_fault_out);
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        rd_d = 1'b0;
    logic        di_in = 1'b0;
    logic        block_in = 1'b0;
    logic        io_fault_in = 1'b0;
    logic [3:0]  addr_in = 4'h0;
    logic [3:0]  light_in = 4'h0;
    logic [3:0]  pres_in = 4'h0;
    logic [7:0]  sens_count_in = 8'h00;
    logic [12:0] ph_cmd = 13'h0000;
    logic [12:0] res_cmd = 13'h0000;
    logic [31:0] wdata_in = 32'h0;
    logic [31:0] rdata_out;
    logic [31:0] exp_q[$];
    wire  logic [3:0]  trip, blkd;
    localparam int CYC = 2000;
    wire  logic [12:0] ph_cur, res_cur;
    wire  logic        sample;
    int          num_errors = 0;
    int          tests_run = 0;
    int          seed = 32'h65571EB3;
    azt_field_model fm (.clock_in, .rst_in, .ph_cmd_in(ph_cmd), .res_cmd_in(res_cmd),
        .ph_out(ph_cur), .res_out(res_cur), .sample_out(sample));
    azt_zone_trip #(.CYC_CLKS(CYC)) dut (.clock_in, .rst_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .light_in, .pres_in, .di_in, .block_in, .io_fault_in,
        .sens_count_in, .ph_cur_in(ph_cur), .res1_cur_in(ph_cur), .res2_cur_in(res_cur),
        .sample_in(sample), .trip_out(trip), .blocked_out(blkd), .ph_start_out(),
        .res_start_out(),
        .ph_blocked_out(), .res_blocked_out(), .sens_fault_out());
    always #20 clock_in = ~clock_in;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask
    // read data checked one cycle after the strobe only
    always @(posedge clock_in) rd_d <= rd_in;
    always @(negedge clock_in) begin
        if (rd_d)
            check("rdata_out", rdata_out, exp_q.pop_front());
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in <= w;
        rd_in <= !w;
        addr_in <= a;
        wdata_in <= d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // zone outputs looked at mid-cycle, away from the launching edge
    task automatic zones(input logic [7:0] e);
        @(negedge clock_in);
        check("zone outputs", {24'h0, blkd, trip}, {24'h0, e});
    endtask
    task automatic idle();
        @(posedge clock_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
    endtask
    // one program cycle plus margin for a sample frame, sync and output register
    task automatic period(input int n);
        repeat (CYC + 1300) @(posedge clock_in);
        $display("program cycle %0d elapsed", n);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        num_errors++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(azt_pkg::A_PH_THR, 32'h78);
        rd(azt_pkg::A_RES_THR, 32'h78);
        rd(azt_pkg::A_RES_SEL, 32'h0);
        rd(4'hF, 32'h0);
        bus(1'b1, azt_pkg::A_ZONE_EN, 32'h7);
        bus(1'b1, azt_pkg::A_PH_EN, 32'h1);
        bus(1'b1, azt_pkg::A_RES_EN, 32'h2);
        bus(1'b1, azt_pkg::A_LIGHT_EN, 32'h1001);
        bus(1'b1, azt_pkg::A_PRES_EN, 32'h20);
        bus(1'b1, azt_pkg::A_DI_MODE, 32'h10);
        bus(1'b1, azt_pkg::A_RES_SEL, 32'h2);
        idle();
        light_in <= 4'h1;
        pres_in <= 4'h2;
        di_in <= 1'b1;
        io_fault_in <= 1'b1;
        ph_cmd <= 13'h0079;
        res_cmd <= 13'h0079;
        period(1);
        zones(8'h07);
        rd(azt_pkg::A_CONDITION, 32'h07);
        rd(azt_pkg::A_SENS_STAT, 32'h0021210A);
        bus(1'b1, azt_pkg::A_RES_SEL, 32'h1);
        idle();
        // limit equal to threshold is not overcurrent
        pres_in <= 4'($random(seed)) & 4'hC;
        di_in <= 1'b0;
        io_fault_in <= 1'b0;
        ph_cmd <= 13'h0078;
        res_cmd <= 13'h0000;
        period(2);
        zones(8'h00);
        rd(azt_pkg::A_CONDITION, 32'h00);
        rd(azt_pkg::A_RES_SEL, 32'h1);
        // block settles through the filter before zone 3 can pick up
        block_in <= 1'b1;
        bus(1'b1, azt_pkg::A_DI_MODE, 32'h20);
        bus(1'b1, azt_pkg::A_SENS_CFG, 32'h01);
        bus(1'b1, azt_pkg::A_ZONE_EN, 32'hF);
        idle();
        pres_in <= 4'h0;
        di_in <= 1'b1;
        ph_cmd <= 13'h0079;
        res_cmd <= 13'h0079;
        period(3);
        zones(8'hD0);
        rd(azt_pkg::A_CONDITION, 32'hD0);
        rd(azt_pkg::A_SENS_STAT, 32'h00030105);
        idle();
        // releasing the block mid-event must not turn it into a trip
        block_in <= 1'b0;
        period(4);
        zones(8'hD0);
        rd(azt_pkg::A_CONDITION, 32'hD0);
        idle();
        idle();
        close_out();
    end
endmodule
`default_nettype wire
